// file: vea_aux_top.sv
`timescale 1ns/100ps
`default_nettype none
module vea_aux_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [17:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        enc_line_start,
  input  wire logic        enc_frame_start,
  input  wire logic        enc_field,
  input  wire logic        pal_mode,
  input  wire logic        mix_valid,
  input  wire logic [23:0] mix_ycc,
  output logic             mix_ready,
  output logic             mixer_hsync_n,
  output logic             mixer_vsync_n,
  output logic             mixer_field,
  output logic             mixer_clk_en,
  output logic             vsync_irq,
  input  wire logic        panel_ready,
  output logic      [7:0]  luma_out_bus,
  output logic             luma_out_oe,
  output logic      [7:0]  chroma_out_bus,
  output logic             chroma_out_oe,
  output logic             hsync_pin_o,
  output logic             hsync_pin_oe,
  output logic             vsync_pin_o,
  output logic             vsync_pin_oe,
  output logic             panel_field_out,
  output logic             panel_field_oe,
  input  wire logic        rgb_valid,
  input  wire logic [23:0] rgb_in,
  output logic             rgb_out_valid,
  output logic      [23:0] rgb_out,
  output logic             gamma_clk_en,
  output logic             panel_clk_en,
  output logic             encoder_clk_en
);

  logic [1:0]  video_processing;
  logic [3:0]  mixer_clock_period_len;
  logic [15:0] mixer_clock_enable_pattern;
  logic [6:0]  mixer_hsync_advance;
  logic [1:0]  sync_control;
  logic [1:0]  video_io_ctrl;
  logic [7:0]  luma_constant_level;
  logic [7:0]  chroma_constant_level;
  logic [1:0]  gamma_ctrl;
  logic [2:0]  section_clock;
  logic [15:0] gamma_table_address;
  logic [15:0] gamma_mem [vea_pkg::GAM_WORDS];

  logic [11:0] hcount;
  logic [11:0] line_len;
  logic        hs_fire;
  logic [3:0]  gate_cnt;
  vea_pkg::vea_vs_state_t vs_state;
  logic [10:0] vs_cnt;
  logic        vs_fire;
  logic        half_line;
  logic        port_wr;
  logic        port_rd;
  logic        chroma_phase;
  logic [23:0] gamma_rgb;

  vea_stream_if in_link ();
  vea_stream_if out_link ();

  function automatic logic [23:0] colorbar(input logic sat, input logic [2:0] idx);
    colorbar = sat ? vea_pkg::CB_100[idx] : vea_pkg::CB_75[idx];
  endfunction

  function automatic logic [7:0] gamma_index(input logic [1:0] comp, input logic [7:0] v,
                                             input logic uq);
    gamma_index = uq ? {comp, v[7:2]} : v;
  endfunction

  function automatic logic [7:0] gamma_pick(input logic [7:0] idx);
    logic [15:0] word;
    word = gamma_mem[idx[7:1]];
    gamma_pick = idx[0] ? word[15:8] : word[7:0];
  endfunction

  assign port_wr   = reg_wr_en && (reg_addr == vea_pkg::OFS_GAMMA_PORT);
  assign port_rd   = reg_rd_en && (reg_addr == vea_pkg::OFS_GAMMA_PORT);
  assign half_line = sync_control[vea_pkg::BIT_HALF_LINE_DELAY] | pal_mode;

  // Software registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      video_processing           <= 2'h0;
      mixer_clock_period_len     <= vea_pkg::RST_PERIOD;
      mixer_clock_enable_pattern <= vea_pkg::RST_PATTERN;
      mixer_hsync_advance        <= 7'h00;
      sync_control               <= 2'h0;
      video_io_ctrl              <= 2'h0;
      luma_constant_level        <= 8'h00;
      chroma_constant_level      <= 8'h00;
      gamma_ctrl                 <= 2'h0;
      section_clock              <= vea_pkg::RST_SECTION;
    end else if (reg_wr_en) begin
      case (reg_addr)
        vea_pkg::OFS_VIDEO_PROCESSING: begin
          video_processing <= reg_wdata[1:0];
        end
        vea_pkg::OFS_MIXER_CLOCK_A: begin
          mixer_clock_period_len <= reg_wdata[3:0];
        end
        vea_pkg::OFS_MIXER_CLOCK_B: begin
          mixer_clock_enable_pattern <= reg_wdata;
        end
        vea_pkg::OFS_HSYNC_ADVANCE: begin
          mixer_hsync_advance <= reg_wdata[6:0];
        end
        vea_pkg::OFS_SYNC_CONTROL: begin
          sync_control <= reg_wdata[1:0];
        end
        vea_pkg::OFS_VIDEO_IO_CTRL: begin
          video_io_ctrl <= reg_wdata[1:0];
        end
        vea_pkg::OFS_CONSTANT_LEVEL: begin
          luma_constant_level   <= reg_wdata[15:8];
          chroma_constant_level <= reg_wdata[7:0];
        end
        vea_pkg::OFS_GAMMA_CTRL: begin
          gamma_ctrl <= reg_wdata[1:0];
        end
        vea_pkg::OFS_SECTION_CLOCK: begin
          section_clock <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Gamma address register, stepped by every data port access.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gamma_table_address <= 16'h0000;
    end else if (reg_wr_en && reg_addr == vea_pkg::OFS_GAMMA_ADDRESS) begin
      gamma_table_address <= reg_wdata;
    end else if (port_wr || port_rd) begin
      gamma_table_address <= gamma_table_address + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < vea_pkg::GAM_WORDS; i++) begin
        gamma_mem[i] <= 16'h0000;
      end
    end else if (port_wr) begin
      gamma_mem[gamma_table_address[6:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd_en) begin
      case (reg_addr)
        vea_pkg::OFS_VIDEO_PROCESSING: reg_rdata <= {14'h0000, video_processing};
        vea_pkg::OFS_MIXER_CLOCK_A:    reg_rdata <= {12'h000, mixer_clock_period_len};
        vea_pkg::OFS_MIXER_CLOCK_B:    reg_rdata <= mixer_clock_enable_pattern;
        vea_pkg::OFS_HSYNC_ADVANCE:    reg_rdata <= {9'h000, mixer_hsync_advance};
        vea_pkg::OFS_SYNC_CONTROL:     reg_rdata <= {14'h0000, sync_control[1], half_line};
        vea_pkg::OFS_ENCODER_STATUS:   reg_rdata <= {15'h0000, mixer_field};
        vea_pkg::OFS_VIDEO_IO_CTRL:    reg_rdata <= {14'h0000, video_io_ctrl};
        vea_pkg::OFS_CONSTANT_LEVEL:   reg_rdata <= {luma_constant_level, chroma_constant_level};
        vea_pkg::OFS_GAMMA_CTRL:       reg_rdata <= {14'h0000, gamma_ctrl};
        vea_pkg::OFS_SECTION_CLOCK:    reg_rdata <= {13'h0000, section_clock};
        vea_pkg::OFS_GAMMA_ADDRESS:    reg_rdata <= gamma_table_address;
        vea_pkg::OFS_GAMMA_PORT:       reg_rdata <= gamma_mem[gamma_table_address[6:0]];
        default:                       reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Horizontal position and measured line length.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hcount   <= 12'h000;
      line_len <= 12'h000;
    end else if (enc_line_start) begin
      hcount   <= 12'h000;
      line_len <= hcount + 12'h001;
    end else begin
      hcount <= hcount + 12'h001;
    end
  end

  // With no advance the mixer line starts with the encoder line, so both
  // count their start offsets from the same edge.
  always_comb begin
    if (mixer_hsync_advance == 7'h00) begin
      hs_fire = enc_line_start;
    end else begin
      hs_fire = (hcount == line_len - {5'h00, mixer_hsync_advance});
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gate_cnt     <= 4'h0;
      mixer_clk_en <= 1'b0;
    end else begin
      if (hs_fire || gate_cnt >= mixer_clock_period_len) begin
        gate_cnt <= 4'h0;
      end else begin
        gate_cnt <= gate_cnt + 4'h1;
      end
      mixer_clk_en <= mixer_clock_enable_pattern[gate_cnt];
    end
  end

  // Vertical sync, optionally held back by half a line.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vs_state <= vea_pkg::VS_IDLE;
      vs_cnt   <= 11'h000;
    end else begin
      case (vs_state)
        vea_pkg::VS_IDLE: begin
          if (enc_frame_start && half_line && line_len[11:1] != 11'h000) begin
            vs_state <= vea_pkg::VS_WAIT;
            vs_cnt   <= line_len[11:1];
          end
        end
        vea_pkg::VS_WAIT: begin
          vs_cnt <= vs_cnt - 11'h001;
          if (vs_cnt == 11'h001) begin
            vs_state <= vea_pkg::VS_IDLE;
          end
        end
        default: begin
          vs_state <= vea_pkg::VS_IDLE;
        end
      endcase
    end
  end

  assign vs_fire = (vs_state == vea_pkg::VS_WAIT) ? (vs_cnt == 11'h001) :
                   (enc_frame_start && !(half_line && line_len[11:1] != 11'h000));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mixer_hsync_n <= 1'b1;
      mixer_vsync_n <= 1'b1;
      mixer_field   <= 1'b0;
      vsync_irq     <= 1'b0;
    end else begin
      mixer_hsync_n <= ~hs_fire;
      mixer_vsync_n <= ~vs_fire;
      if (vs_fire) begin
        mixer_field <= enc_field;
      end
      // The mixer loads its shadow registers on the low vsync cycle, the
      // interrupt pulse comes on the cycle after.
      vsync_irq <= ~mixer_vsync_n;
    end
  end

  // Encoder sync pins and their direction.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hsync_pin_o     <= 1'b1;
      vsync_pin_o     <= 1'b1;
      panel_field_out <= 1'b0;
      hsync_pin_oe    <= 1'b0;
      vsync_pin_oe    <= 1'b0;
      panel_field_oe  <= 1'b0;
    end else begin
      hsync_pin_o     <= ~enc_line_start;
      vsync_pin_o     <= ~enc_frame_start;
      panel_field_out <= enc_field;
      hsync_pin_oe    <= sync_control[vea_pkg::BIT_SYNC_PIN_DIR];
      vsync_pin_oe    <= sync_control[vea_pkg::BIT_SYNC_PIN_DIR];
      panel_field_oe  <= sync_control[vea_pkg::BIT_SYNC_PIN_DIR];
    end
  end

  // Video path: colour bars or mixer video into the two-entry buffer.
  assign in_link.valid = video_processing[vea_pkg::BIT_COLORBAR_ENABLE] ? 1'b1 : mix_valid;
  assign in_link.data  = video_processing[vea_pkg::BIT_COLORBAR_ENABLE] ?
                         colorbar(video_processing[vea_pkg::BIT_COLORBAR_SAT],
                                  hcount[vea_pkg::COLORBAR_SHIFT +: 3]) : mix_ycc;
  assign mix_ready     = in_link.ready & ~video_processing[vea_pkg::BIT_COLORBAR_ENABLE];
  assign out_link.ready = panel_ready & section_clock[vea_pkg::BIT_CLK_ENCODER];

  vea_pair_buffer u_buffer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .in_s    (in_link),
    .out_s   (out_link)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      luma_out_bus   <= 8'h00;
      chroma_out_bus <= 8'h00;
      chroma_phase   <= 1'b0;
    end else if (video_io_ctrl[vea_pkg::BIT_DIRECT_LEVEL]) begin
      luma_out_bus   <= luma_constant_level;
      chroma_out_bus <= chroma_constant_level;
    end else if (out_link.valid && out_link.ready) begin
      luma_out_bus   <= out_link.data[23:16];
      chroma_out_bus <= chroma_phase ? out_link.data[7:0] : out_link.data[15:8];
      chroma_phase   <= ~chroma_phase;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      luma_out_oe   <= 1'b0;
      chroma_out_oe <= 1'b0;
    end else begin
      luma_out_oe   <= video_io_ctrl[vea_pkg::BIT_YC_PIN_DIR];
      chroma_out_oe <= video_io_ctrl[vea_pkg::BIT_YC_PIN_DIR];
    end
  end

  // Gamma lookup, one stage per component.
  for (genvar c = 0; c < 3; c++) begin : g_gamma
    assign gamma_rgb[c*8 +: 8] = gamma_pick(gamma_index(2'(2 - c), rgb_in[c*8 +: 8],
                                            gamma_ctrl[vea_pkg::BIT_GAMMA_PER_COMP]));
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rgb_out       <= 24'h00_0000;
      rgb_out_valid <= 1'b0;
    end else if (section_clock[vea_pkg::BIT_CLK_PANEL]) begin
      rgb_out_valid <= rgb_valid;
      if (gamma_ctrl[vea_pkg::BIT_GAMMA_ON] && section_clock[vea_pkg::BIT_CLK_GAMMA]) begin
        rgb_out <= gamma_rgb;
      end else begin
        rgb_out <= rgb_in;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gamma_clk_en   <= 1'b0;
      panel_clk_en   <= 1'b0;
      encoder_clk_en <= 1'b0;
    end else begin
      gamma_clk_en   <= section_clock[vea_pkg::BIT_CLK_GAMMA];
      panel_clk_en   <= section_clock[vea_pkg::BIT_CLK_PANEL];
      encoder_clk_en <= section_clock[vea_pkg::BIT_CLK_ENCODER];
    end
  end

endmodule // vea_aux_top
`default_nettype wire

// file: vea_pkg.sv
package vea_pkg;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PIX_W  = 24;
  localparam int unsigned HCNT_W = 12;
  localparam int unsigned PER_W  = 4;
  localparam int unsigned PAT_W  = 16;
  localparam int unsigned ADV_W  = 7;
  localparam int unsigned GAM_WORDS = 128;

  // Register offsets on the register port.
  localparam logic [17:0] OFS_VIDEO_PROCESSING = 18'h3_1400;
  localparam logic [17:0] OFS_MIXER_CLOCK_A    = 18'h3_1402;
  localparam logic [17:0] OFS_MIXER_CLOCK_B    = 18'h3_1404;
  localparam logic [17:0] OFS_HSYNC_ADVANCE    = 18'h3_1406;
  localparam logic [17:0] OFS_SYNC_CONTROL     = 18'h3_1408;
  localparam logic [17:0] OFS_ENCODER_STATUS   = 18'h3_140A;
  localparam logic [17:0] OFS_VIDEO_IO_CTRL    = 18'h3_140C;
  localparam logic [17:0] OFS_CONSTANT_LEVEL   = 18'h3_140E;
  localparam logic [17:0] OFS_GAMMA_CTRL       = 18'h3_1410;
  localparam logic [17:0] OFS_SECTION_CLOCK    = 18'h3_1412;
  localparam logic [17:0] OFS_GAMMA_ADDRESS    = 18'h3_145E;
  localparam logic [17:0] OFS_GAMMA_PORT       = 18'h3_1460;

  // Field positions.
  localparam int unsigned BIT_COLORBAR_ENABLE  = 0;
  localparam int unsigned BIT_COLORBAR_SAT     = 1;
  localparam int unsigned BIT_HALF_LINE_DELAY  = 0;
  localparam int unsigned BIT_SYNC_PIN_DIR     = 1;
  localparam int unsigned BIT_FIELD_ID         = 0;
  localparam int unsigned BIT_DIRECT_LEVEL     = 0;
  localparam int unsigned BIT_YC_PIN_DIR       = 1;
  localparam int unsigned BIT_GAMMA_ON         = 0;
  localparam int unsigned BIT_GAMMA_PER_COMP   = 1;
  localparam int unsigned BIT_CLK_GAMMA        = 0;
  localparam int unsigned BIT_CLK_PANEL        = 1;
  localparam int unsigned BIT_CLK_ENCODER      = 2;
  localparam int unsigned COLORBAR_SHIFT       = 7;

  // Values after reset.
  localparam logic [3:0]  RST_PERIOD  = 4'h1;
  localparam logic [15:0] RST_PATTERN = 16'h0002;
  localparam logic [2:0]  RST_SECTION = 3'h7;

  // Colour bar Y/Cb/Cr, element 0 is black, element 7 is white.
  localparam logic [7:0][23:0] CB_100 = {24'hEB_8080, 24'hD2_1092, 24'hAA_A610, 24'h91_3622,
                                         24'h6A_CADE, 24'h51_5AF0, 24'h29_F06E, 24'h10_8080};
  localparam logic [7:0][23:0] CB_75  = {24'hB4_8080, 24'hA2_2C8E, 24'h83_9C2C, 24'h70_483A,
                                         24'h54_B8C6, 24'h41_64D4, 24'h23_D472, 24'h10_8080};

  typedef enum logic {VS_IDLE = 1'b0, VS_WAIT = 1'b1} vea_vs_state_t;

endpackage

// file: vea_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vea_stream_if;
  logic                       valid;
  logic                       ready;
  logic [vea_pkg::PIX_W-1:0]  data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: vea_pair_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module vea_pair_buffer (
  input  wire logic ref_clk,
  input  wire logic nrst,
  vea_stream_if.rx  in_s,
  vea_stream_if.tx  out_s
);
  logic [vea_pkg::PIX_W-1:0] slot [2];
  logic                      wp;
  logic                      rp;
  logic [1:0]                count;
  logic [1:0]                next_count;
  logic                      push;
  logic                      pop;

  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;
  assign out_s.valid = (count != 2'd0);
  assign out_s.data  = slot[rp];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'd1;
    end else if (pop && !push) begin
      next_count = count - 2'd1;
    end
  end

  // Ready is a flop so the filling side never sees a combinational path.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count      <= 2'd0;
      in_s.ready <= 1'b0;
    end else begin
      count      <= next_count;
      in_s.ready <= (next_count != 2'd2);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp <= 1'b0;
      rp <= 1'b0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot[wp] <= in_s.data;
    end
  end
endmodule // vea_pair_buffer
`default_nettype wire

// file: vea_aux_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module vea_aux_assertions (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        reg_rd_en,
  input wire logic [17:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        enc_line_start,
  input wire logic        mixer_hsync_n,
  input wire logic        mixer_vsync_n,
  input wire logic        mixer_field,
  input wire logic        vsync_irq,
  input wire logic        luma_out_oe,
  input wire logic        chroma_out_oe,
  input wire logic        hsync_pin_o,
  input wire logic        hsync_pin_oe,
  input wire logic        vsync_pin_oe,
  input wire logic        panel_field_oe
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence vs_start;
    $fell(mixer_vsync_n);
  endsequence
  sequence irq_pulse;
    vsync_irq ##1 !vsync_irq;
  endsequence
  a_irq_on_vsync: assert property (vs_start |=> irq_pulse)
    else $error("vsync interrupt missing");
  a_irq_cause: assert property (vsync_irq |-> $past(mixer_vsync_n) == 1'b0)
    else $error("interrupt without vsync");
  a_hsync_pulse: assert property ($fell(mixer_hsync_n) |=> mixer_hsync_n)
    else $error("hsync pulse too long");
  a_vsync_pulse: assert property (vs_start |=> mixer_vsync_n)
    else $error("vsync pulse too long");
  a_field_update: assert property ($changed(mixer_field) |-> vs_start)
    else $error("field moved without vsync");
  a_field_status: assert property (reg_rd_en && reg_addr == vea_pkg::OFS_ENCODER_STATUS
    |=> reg_rdata[0] == $past(mixer_field)) else $error("status field wrong");
  a_yc_oe_pair: assert property (luma_out_oe == chroma_out_oe)
    else $error("bus enables differ");
  a_sync_oe_one: assert property (hsync_pin_oe == vsync_pin_oe
    && vsync_pin_oe == panel_field_oe) else $error("sync enables differ");
  a_hsync_pin: assert property (enc_line_start |=> !hsync_pin_o)
    else $error("hsync pin not low");
endmodule // vea_aux_assertions
bind vea_aux_top vea_aux_assertions vea_aux_assertions_i (
  .ref_clk(ref_clk), .nrst(nrst), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .enc_line_start(enc_line_start), .mixer_hsync_n(mixer_hsync_n),
  .mixer_vsync_n(mixer_vsync_n), .mixer_field(mixer_field), .vsync_irq(vsync_irq),
  .luma_out_oe(luma_out_oe), .chroma_out_oe(chroma_out_oe), .hsync_pin_o(hsync_pin_o),
  .hsync_pin_oe(hsync_pin_oe), .vsync_pin_oe(vsync_pin_oe), .panel_field_oe(panel_field_oe)
);
`default_nettype wire

// file: vea_mixer_model.sv
`timescale 1ns/100ps
`default_nettype none
module vea_mixer_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic        mix_ready,
  output logic             mix_valid,
  output logic      [23:0] mix_ycc
);
  logic [7:0] luma = 8'h01;
  logic       taken = 1'b0;
  initial mix_valid = 1'b0;
  always @(posedge ref_clk) taken <= mix_valid && mix_ready;
  // An offered word is held until the block has taken it.
  always @(negedge ref_clk) begin
    if (taken) luma <= luma + 8'h01;
    if (!mix_valid || taken) mix_valid <= go;
  end
  // A word not on offer shows its inverse, so no stale value can pass.
  assign mix_ycc = mix_valid ? {luma, 16'h8080} : ~{luma, 16'h8080};
endmodule // vea_mixer_model
`default_nettype wire

// file: test_video_encoder_aux_features.sv
`timescale 1ns/100ps
`default_nettype none
module test_video_encoder_aux_features;
  typedef struct packed {logic wr; logic [17:0] a; logic [15:0] d; logic [15:0] e;} vea_row_t;
  localparam logic [17:0] PER = vea_pkg::OFS_MIXER_CLOCK_A, PAT = vea_pkg::OFS_MIXER_CLOCK_B;
  localparam logic [17:0] ADV = vea_pkg::OFS_HSYNC_ADVANCE, SYN = vea_pkg::OFS_SYNC_CONTROL;
  localparam logic [17:0] GAD = vea_pkg::OFS_GAMMA_ADDRESS, GPT = vea_pkg::OFS_GAMMA_PORT;
  localparam logic [17:0] IOC = vea_pkg::OFS_VIDEO_IO_CTRL, STA = vea_pkg::OFS_ENCODER_STATUS;
  logic        ref_clk = 0, nrst = 0, reg_wr_en = 0, reg_rd_en = 0, go = 0;
  logic        enc_line_start = 0, enc_frame_start = 0, enc_field = 0, pal_mode = 0;
  logic        panel_ready = 0, rgb_valid = 0, mix_valid, mix_ready, mixer_hsync_n;
  logic        mixer_vsync_n, mixer_field, mixer_clk_en, vsync_irq, luma_out_oe;
  logic        chroma_out_oe, hsync_pin_o, hsync_pin_oe, vsync_pin_o, vsync_pin_oe;
  logic        panel_field_out, panel_field_oe, rgb_out_valid;
  logic        gamma_clk_en, panel_clk_en, encoder_clk_en;
  logic [17:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic [23:0] mix_ycc, rgb_out, rgb_in = '0;
  logic [7:0]  luma_out_bus, chroma_out_bus, prev;
  int          mismatches = 0, num_checks = 0, cyc = 0, t, c, np, d[3], v[3];
  vea_row_t    rows [9] = '{'{0, PER, 0, 1}, '{0, PAT, 0, 2},
    '{0, vea_pkg::OFS_SECTION_CLOCK, 0, 7}, '{0, GPT, 0, 0}, '{0, 18'h3_1500, 0, 0},
    '{1, STA, 1, 0}, '{1, ADV, 16'h007f, 16'h007f}, '{1, PER, 0, 0}, '{1, PAT, 1, 1}};

  vea_aux_top vea_aux_top_i (.ref_clk, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .enc_line_start, .enc_frame_start, .enc_field, .pal_mode, .mix_valid,
    .mix_ycc, .mix_ready, .mixer_hsync_n, .mixer_vsync_n, .mixer_field, .mixer_clk_en,
    .vsync_irq, .panel_ready, .luma_out_bus, .luma_out_oe, .chroma_out_bus, .chroma_out_oe,
    .hsync_pin_o, .hsync_pin_oe, .vsync_pin_o, .vsync_pin_oe, .panel_field_out,
    .panel_field_oe, .rgb_valid, .rgb_in, .rgb_out_valid, .rgb_out, .gamma_clk_en,
    .panel_clk_en, .encoder_clk_en);
  vea_mixer_model vea_mixer_model_i (.ref_clk, .go, .mix_ready, .mix_valid, .mix_ycc);

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] dat);
    @(negedge ref_clk);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = dat;
    @(negedge ref_clk);
    reg_wr_en = 0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    reg_rd_en = 1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 0;
    chk(reg_rdata, e);
  endtask
  task automatic pulse(input bit f);
    @(negedge ref_clk);
    enc_frame_start = f;
    enc_line_start = !f;
    @(negedge ref_clk);
    enc_frame_start = 0;
    enc_line_start = 0;
  endtask
  task automatic wait_low(input bit vs);
    int n = 0;
    while ((vs ? mixer_vsync_n : mixer_hsync_n) !== 1'b0 && n < 900) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic gate(output int cnt);
    cnt = 0;
    repeat (30) begin
      @(negedge ref_clk);
      cnt += mixer_clk_en;
    end
  endtask
  function automatic logic [7:0] g(input int i);
    return ~i[7:0];
  endfunction
  function automatic logic [15:0] word(input int k);
    return {g(2 * k + 1), g(2 * k)};
  endfunction
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    chk({mixer_hsync_n, mixer_vsync_n, luma_out_oe, vsync_irq}, 4'b1100);
    @(negedge ref_clk);
    nrst = 1;
    panel_ready = 1;
    gate(c);
    chk(c, 15);
    chk({gamma_clk_en, panel_clk_en, encoder_clk_en}, 3'h7);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    gate(c);
    chk(c, 30);
    wr(PER, 16'h0002);
    wr(PAT, 16'h0002);
    repeat (3) @(negedge ref_clk);
    gate(c);
    chk(c, 10);
    wr(GAD, 16'h0000);
    for (int k = 0; k < 128; k++) wr(GPT, word(k));
    wr(GAD, 16'h0005);
    rd(GPT, word(5));
    rd(GPT, word(6));
    wr(vea_pkg::OFS_GAMMA_CTRL, 16'h0001);
    rgb_valid = 1;
    rgb_in = 24'h12_3456;
    @(negedge ref_clk);
    chk(rgb_out, {g(8'h12), g(8'h34), g(8'h56)});
    wr(vea_pkg::OFS_GAMMA_CTRL, 16'h0003);
    @(negedge ref_clk);
    chk(rgb_out, {g(8'h12 >> 2), g(64 + (8'h34 >> 2)), g(128 + (8'h56 >> 2))});
    wr(vea_pkg::OFS_SECTION_CLOCK, 16'h0000);
    @(negedge ref_clk);
    chk({gamma_clk_en, panel_clk_en, encoder_clk_en, rgb_out_valid}, 4'h1);
    wr(vea_pkg::OFS_SECTION_CLOCK, 16'h0007);
    wr(vea_pkg::OFS_CONSTANT_LEVEL, 16'h5a3c);
    wr(IOC, 16'h0003);
    @(negedge ref_clk);
    chk({luma_out_oe, chroma_out_oe, luma_out_bus, chroma_out_bus}, 18'h3_5a3c);
    wr(IOC, 16'h0000);
    wr(SYN, 16'h0002);
    @(negedge ref_clk);
    chk({luma_out_oe, hsync_pin_oe, vsync_pin_oe, panel_field_oe}, 4'h7);
    wr(SYN, 16'h0000);
    wr(vea_pkg::OFS_VIDEO_PROCESSING, 16'h0003);
    pulse(0);
    repeat (60) @(negedge ref_clk);
    chk({luma_out_bus, chroma_out_bus, mix_ready}, 17'h0_2100);
    repeat (900) @(negedge ref_clk);
    chk({luma_out_bus, chroma_out_bus}, 16'heb80);
    wr(vea_pkg::OFS_VIDEO_PROCESSING, 16'h0001);
    repeat (3) @(negedge ref_clk);
    chk({luma_out_bus, chroma_out_bus}, 16'hb480);
    wr(vea_pkg::OFS_VIDEO_PROCESSING, 16'h0000);
    go = 1;
    repeat (4) @(negedge ref_clk);
    panel_ready = 0;
    repeat (6) @(negedge ref_clk);
    chk(mix_ready, 1'b0);
    prev = luma_out_bus;
    panel_ready = 1;
    np = 0;
    repeat (12) begin
      @(negedge ref_clk);
      if (luma_out_bus !== prev) begin
        chk(luma_out_bus, prev + 8'h01);
        prev = luma_out_bus;
        np++;
      end
    end
    chk(np >= 6, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(ADV, 16'(10 * i));
      pulse(0);
      t = cyc;
      wait_low(0);
      d[i] = cyc - t;
      while (cyc < t + 195) @(negedge ref_clk);
    end
    chk(d[0], 0);
    chk(d[1] - d[2], 10);
    enc_field = 1;
    for (int i = 0; i < 3; i++) begin
      wr(SYN, {15'h0000, i == 1});
      pal_mode = (i == 2);
      pulse(1);
      chk(vsync_pin_o, 1'b0);
      t = cyc;
      wait_low(1);
      v[i] = cyc - t;
    end
    chk(v[1] - v[0], 99);
    chk(v[2] - v[0], 99);
    rd(SYN, 16'h0001);
    rd(STA, 16'h0001);
    chk(panel_field_out, 1'b1);
    finish_test;
  end
endmodule // test_video_encoder_aux_features
`default_nettype wire
